// File: rtl/pwrini_top.v
// power-up reset, configuration load, address strap decode and enable qualification
`timescale 1ns/1ps
`default_nettype none
`include "pwrini_map.vh"
module pwrini_top (
   input wire CLK_I,
   input wire SRST_I,
   input wire BIAS_GOOD_I,
   input wire CORE_RAIL_1V8_GOOD_I,
   input wire OSC_STABLE_I,
   input wire ENABLE_FORCED_MODE_PIN_I,
   input wire [7:0] VIN_LEVEL_I,
   output wire ADC_START_O,
   input wire ADC_DONE_I,
   input wire [9:0] ADC_DATA_I,
   input wire CMD_WE_I,
   input wire [3:0] CMD_IDX_I,
   input wire [7:0] CMD_DATA_I,
   output wire CMD_READY_O,
   output reg [6:0] I2C_SLAVE_ID_O,
   output reg [6:0] PMBUS_SLAVE_ID_O,
   output reg I2C_ON_O,
   output reg PMBUS_ON_O,
   output reg ANALOG_MODE_O,
   output reg INIT_DONE_O,
   output reg CONVERT_EN_O
);
   // ----------------------------------------
   // state codes
   // ----------------------------------------
   localparam [4:0] ST_POR = 5'h01;
   localparam [4:0] ST_LOAD = 5'h02;
   localparam [4:0] ST_ADC = 5'h04;
   localparam [4:0] ST_WAIT = 5'h08;
   localparam [4:0] ST_RUN = 5'h10;

   // ----------------------------------------
   // input synchronisers
   // ----------------------------------------
   reg [3:0] sync_a;
   reg [3:0] sync_b;
   reg adc_done_a;
   reg adc_done_b;
   reg [9:0] adc_data_a;
   reg [9:0] adc_data_b;
   reg [7:0] vin_a;
   reg [7:0] vin_b;
   wire bias_ok = sync_b[0];
   wire core_ok = sync_b[1];
   wire osc_ok = sync_b[2];
   wire en_pin = sync_b[3];

   // two-flop sync of pins and converter signals
   always @(posedge CLK_I) begin
      sync_a <= {ENABLE_FORCED_MODE_PIN_I, OSC_STABLE_I, CORE_RAIL_1V8_GOOD_I, BIAS_GOOD_I};
      sync_b <= sync_a;
      adc_done_a <= ADC_DONE_I;
      adc_done_b <= adc_done_a;
      adc_data_a <= ADC_DATA_I;
      adc_data_b <= adc_data_a;
      vin_a <= VIN_LEVEL_I;
      vin_b <= vin_a;
   end

   // ----------------------------------------
   // state and working registers
   // ----------------------------------------
   reg [4:0] state;
   reg [3:0] rd_idx;
   reg [3:0] wr_idx;
   reg load_vld;
   reg load_last;
   reg adc_req;
   reg [3:0] offset;
   reg [6:0] i2c_base_slave_id;
   reg [6:0] pmbus_base_slave_id;
   reg [7:0] vin_on;
   reg [7:0] vin_off;
   reg [1:0] en_src;
   reg sw_enable;
   reg vin_ok;
   wire [7:0] nv_rdata;
   wire por_hold = ~(bias_ok & core_ok & osc_ok);
   wire ready = (state == ST_RUN);
   wire bus_wr = CMD_WE_I & ready & ~ANALOG_MODE_O;
   wire loading = (state == ST_LOAD);

   pwrini_nvstore u_nv (
      .clk_i(CLK_I),
      .we_i(1'b0),
      .waddr_i(4'h0),
      .wdata_i(8'h00),
      .raddr_i(rd_idx),
      .rdata_o(nv_rdata)
   );

   assign ADC_START_O = adc_req;
   assign CMD_READY_O = ready & ~ANALOG_MODE_O;

   // sequencer: reset hold, store copy, strap sample, run
   always @(posedge CLK_I) begin
      if (SRST_I | por_hold) begin
         state <= ST_POR;
         rd_idx <= 4'h0;
         wr_idx <= 4'h0;
         load_vld <= 1'b0;
         load_last <= 1'b0;
         adc_req <= 1'b0;
         offset <= 4'h0;
         ANALOG_MODE_O <= 1'b0;
         INIT_DONE_O <= 1'b0;
      end else begin
         case (state)
            ST_POR: begin
               state <= ST_LOAD;
               rd_idx <= 4'h0;
               load_vld <= 1'b0;
               load_last <= 1'b0;
            end
            ST_LOAD: begin
               // read pipeline: data arrives one cycle after index
               load_vld <= 1'b1;
               wr_idx <= rd_idx;
               if (rd_idx != 4'hf) begin
                  rd_idx <= rd_idx + 4'h1;
               end
               if (load_vld & (wr_idx == 4'he)) begin
                  load_last <= 1'b1;
               end
               if (load_last) begin
                  state <= ST_ADC;
                  adc_req <= 1'b1;
               end
            end
            ST_ADC: begin
               state <= ST_WAIT;
            end
            ST_WAIT: begin
               if (adc_done_b) begin
                  adc_req <= 1'b0;
                  // floating strap reads at the top of the scale
                  if (adc_data_b >= `PWRINI_ADC_FLOAT) begin
                     ANALOG_MODE_O <= 1'b1;
                  end else begin
                     offset <= adc_data_b[9:6];
                  end
                  state <= ST_RUN;
                  INIT_DONE_O <= 1'b1;
               end
            end
            ST_RUN: begin
               state <= ST_RUN;
            end
            default: begin
               state <= ST_POR;
            end
         endcase
      end
   end

   // working registers: loaded from store, then rewritable by the bus
   always @(posedge CLK_I) begin
      if (SRST_I) begin
         i2c_base_slave_id <= `PWRINI_I2C_BASE_RST;
         pmbus_base_slave_id <= `PWRINI_PMB_BASE_RST;
         vin_on <= `PWRINI_UV_DEF;
         vin_off <= `PWRINI_UV_DEF;
         en_src <= `PWRINI_ENSRC_PIN;
         sw_enable <= 1'b0;
      end else if (loading & load_vld) begin
         case (wr_idx)
            `PWRINI_IDX_I2C: i2c_base_slave_id <= nv_rdata[6:0];
            `PWRINI_IDX_PMB: pmbus_base_slave_id <= nv_rdata[6:0];
            `PWRINI_IDX_VINON: vin_on <= nv_rdata;
            `PWRINI_IDX_VINOFF: vin_off <= nv_rdata;
            `PWRINI_IDX_ENSRC: begin
               en_src <= nv_rdata[1:0];
               sw_enable <= nv_rdata[2];
            end
            default: begin
            end
         endcase
      end else if (bus_wr) begin
         case (CMD_IDX_I)
            `PWRINI_IDX_I2C: i2c_base_slave_id <= CMD_DATA_I[6:0];
            `PWRINI_IDX_PMB: pmbus_base_slave_id <= CMD_DATA_I[6:0];
            `PWRINI_IDX_VINON: vin_on <= CMD_DATA_I;
            `PWRINI_IDX_VINOFF: vin_off <= CMD_DATA_I;
            `PWRINI_IDX_ENSRC: begin
               en_src <= CMD_DATA_I[1:0];
               sw_enable <= CMD_DATA_I[2];
            end
            default: begin
            end
         endcase
      end
   end

   // bus undervoltage with separate on and off levels
   always @(posedge CLK_I) begin
      if (SRST_I | ~ready) begin
         vin_ok <= 1'b0;
      end else if (vin_b >= vin_on) begin
         vin_ok <= 1'b1;
      end else if (vin_b < vin_off) begin
         vin_ok <= 1'b0;
      end
   end

   // address formation and conversion qualification
   always @(posedge CLK_I) begin
      if (SRST_I) begin
         I2C_SLAVE_ID_O <= 7'h00;
         PMBUS_SLAVE_ID_O <= 7'h00;
         I2C_ON_O <= 1'b0;
         PMBUS_ON_O <= 1'b0;
         CONVERT_EN_O <= 1'b0;
      end else begin
         I2C_SLAVE_ID_O <= i2c_base_slave_id + {3'h0, offset};
         PMBUS_SLAVE_ID_O <= pmbus_base_slave_id + {3'h0, offset};
         I2C_ON_O <= ready & ~ANALOG_MODE_O & (i2c_base_slave_id != 7'h00);
         PMBUS_ON_O <= ready & ~ANALOG_MODE_O & (pmbus_base_slave_id != 7'h00);
         if (~ready) begin
            CONVERT_EN_O <= 1'b0;
         end else if (ANALOG_MODE_O | (en_src == `PWRINI_ENSRC_PIN)) begin
            CONVERT_EN_O <= en_pin & vin_ok;
         end else if (en_src == `PWRINI_ENSRC_SW) begin
            CONVERT_EN_O <= sw_enable & vin_ok;
         end else begin
            CONVERT_EN_O <= sw_enable & en_pin & vin_ok;
         end
      end
   end
endmodule
`default_nettype wire

// File: inc/pwrini_map.vh
// address map, field values and register defaults of the power-up initialisation block
`ifndef PWRINI_MAP_VH
`define PWRINI_MAP_VH
// ----------------------------------------
// register defaults
// ----------------------------------------
`define PWRINI_I2C_BASE_RST 7'h10
`define PWRINI_PMB_BASE_RST 7'h40
`define PWRINI_ADDR_W 7
// ----------------------------------------
// nonvolatile store and working registers
// ----------------------------------------
`define PWRINI_NV_DEPTH 16
`define PWRINI_NV_AW 4
`define PWRINI_NV_DW 8
`define PWRINI_IDX_I2C 4'h0
`define PWRINI_IDX_PMB 4'h1
`define PWRINI_IDX_VINON 4'h2
`define PWRINI_IDX_VINOFF 4'h3
`define PWRINI_IDX_ENSRC 4'h4
// ----------------------------------------
// strap converter
// ----------------------------------------
`define PWRINI_ADC_W 10
`define PWRINI_ADC_FLOAT 10'h3f0
`define PWRINI_UV_DEF 8'h20
// ----------------------------------------
// enable source select
// ----------------------------------------
`define PWRINI_ENSRC_PIN 2'h0
`define PWRINI_ENSRC_SW 2'h1
`define PWRINI_ENSRC_BOTH 2'h2
`endif

// File: rtl/pwrini_nvstore.v
// nonvolatile configuration store, registered read port, programming write port
`timescale 1ns/1ps
`default_nettype none
`include "pwrini_map.vh"
module pwrini_nvstore (
   input wire clk_i,
   input wire we_i,
   input wire [`PWRINI_NV_AW-1:0] waddr_i,
   input wire [`PWRINI_NV_DW-1:0] wdata_i,
   input wire [`PWRINI_NV_AW-1:0] raddr_i,
   output reg [`PWRINI_NV_DW-1:0] rdata_o
);
   reg [`PWRINI_NV_DW-1:0] mem [0:`PWRINI_NV_DEPTH-1];
   integer k;
   // factory image: base addresses and undervoltage levels
   initial begin
      for (k = 0; k < `PWRINI_NV_DEPTH; k = k + 1) begin
         mem[k] = 8'h00;
      end
      mem[`PWRINI_IDX_I2C] = {1'b0, `PWRINI_I2C_BASE_RST};
      mem[`PWRINI_IDX_PMB] = {1'b0, `PWRINI_PMB_BASE_RST};
      mem[`PWRINI_IDX_VINON] = `PWRINI_UV_DEF;
      mem[`PWRINI_IDX_VINOFF] = `PWRINI_UV_DEF;
   end
   // write and registered read
   always @(posedge clk_i) begin
      if (we_i) begin
         mem[waddr_i] <= wdata_i;
      end
      rdata_o <= mem[raddr_i];
   end
endmodule
`default_nettype wire

// File: sim/pwrini_chk.sv
// port assertions of the power-up initialisation block
`timescale 1ns/1ps
`default_nettype none
module pwrini_chk (
   input wire logic CLK_I,
   input wire logic SRST_I,
   input wire logic BIAS_GOOD_I,
   input wire logic ADC_START_O,
   input wire logic ADC_DONE_I,
   input wire logic CMD_WE_I,
   input wire logic [3:0] CMD_IDX_I,
   input wire logic [7:0] CMD_DATA_I,
   input wire logic CMD_READY_O,
   input wire logic [6:0] I2C_SLAVE_ID_O,
   input wire logic [6:0] PMBUS_SLAVE_ID_O,
   input wire logic I2C_ON_O,
   input wire logic PMBUS_ON_O,
   input wire logic ANALOG_MODE_O,
   input wire logic INIT_DONE_O,
   input wire logic CONVERT_EN_O
);
   default clocking cb @(posedge CLK_I);
   endclocking
   default disable iff (SRST_I);
   // accepted writes to the two base fields
   sequence s_wr0;
      CMD_WE_I && CMD_READY_O && CMD_IDX_I == 4'h0;
   endsequence
   sequence s_wr1;
      CMD_WE_I && CMD_READY_O && CMD_IDX_I == 4'h1;
   endsequence
   // strap answer seen while sampling
   sequence s_strap;
      $rose(ADC_DONE_I) && ADC_START_O;
   endsequence
   a_ready_after_init: assert property (CMD_READY_O |-> INIT_DONE_O && !ANALOG_MODE_O)
      else $error("write port open too early or in analog mode");
   a_conv_after_init: assert property ($rose(CONVERT_EN_O) |-> INIT_DONE_O)
      else $error("conversion started before init");
   a_analog_bus_off: assert property (ANALOG_MODE_O |-> !I2C_ON_O && !PMBUS_ON_O)
      else $error("bus enabled in analog mode");
   a_supply_resets: assert property ($fell(BIAS_GOOD_I) |-> ##[1:5] !INIT_DONE_O)
      else $error("init not withdrawn on supply loss");
   a_strap_sampled: assert property (s_strap |-> ##[2:4] INIT_DONE_O)
      else $error("init not done after strap reading");
   a_sample_once: assert property (INIT_DONE_O |-> !ADC_START_O)
      else $error("strap sampled again after init");
   a_i2c_zero_off: assert property (s_wr0 |-> ##2 I2C_ON_O == |$past(CMD_DATA_I[6:0], 2))
      else $error("i2c enable does not follow base field");
   a_pmb_zero_off: assert property (s_wr1 |-> ##2 PMBUS_ON_O == |$past(CMD_DATA_I[6:0], 2))
      else $error("pmbus enable does not follow base field");
   a_analog_frozen: assert property (ANALOG_MODE_O && $past(ANALOG_MODE_O)
      |-> $stable(I2C_SLAVE_ID_O) && $stable(PMBUS_SLAVE_ID_O))
      else $error("configuration changed in analog mode");
endmodule
bind pwrini_top pwrini_chk u_chk (.CLK_I, .SRST_I, .BIAS_GOOD_I, .ADC_START_O, .ADC_DONE_I, .CMD_WE_I,
   .CMD_IDX_I, .CMD_DATA_I, .CMD_READY_O, .I2C_SLAVE_ID_O, .PMBUS_SLAVE_ID_O, .I2C_ON_O, .PMBUS_ON_O,
   .ANALOG_MODE_O, .INIT_DONE_O, .CONVERT_EN_O);
`default_nettype wire

// File: sim/pwrini_host.sv
// bus host model issuing register writes
`timescale 1ns/1ps
`default_nettype none
module pwrini_host (
   input wire logic clk_i,
   input wire logic ready_i,
   output var logic we_o,
   output var logic [3:0] idx_o,
   output var logic [7:0] data_o
);
   initial begin
      we_o = 1'b0;
      idx_o = 4'h0;
      data_o = 8'h00;
   end
   // one write after a gap; waits for the port unless pushed
   task automatic wr(input logic [3:0] i, input logic [7:0] d, input bit push, input int gap, output bit ok);
      int n;
      ok = push;
      repeat (gap) @(negedge clk_i);
      for (n = 0; n < 100 && !ok; n++) begin
         @(negedge clk_i);
         ok = ready_i === 1'b1;
      end
      idx_o = i;
      data_o = d;
      we_o = 1'b1;
      @(negedge clk_i);
      we_o = 1'b0;
      idx_o = ~i; // released lines carry junk
      data_o = ~d;
   endtask
endmodule
`default_nettype wire

// File: sim/pwrini_top_tb.sv
// self-checking bench of the power-up initialisation block
`timescale 1ns/1ps
`default_nettype none
module pwrini_top_tb;
   localparam logic [19:0] M_ALL = 20'hfffff, M_FLG = 20'hfc000, M_CONV = 20'h08000;
   logic clk = 0, srst = 1, bias = 1, core = 1, osc = 1, pin = 0, adc_done = 0, ok;
   logic [7:0] vin = 8'h30;
   logic [9:0] adc = 10'h0;
   logic [6:0] of, d, e;
   logic [5:0] rb;
   logic [39:0] q[$];
   logic [4:0] src_tab [6] = '{5'b000_0_0, 5'b101_0_1, 5'b110_0_0, 5'b110_1_1, 5'b010_1_0, 5'b000_1_1};
   logic [8:0] vin_tab [5] = '{9'h060, 9'h081, 9'h073, 9'h06e, 9'h081};
   integer seed = 63753, fail_count = 0, n_tests = 0, k;
   event smp;
   wire logic we, adc_start, ready, i2c_on, pmb_on, analog, init, conv;
   wire logic [3:0] idx;
   wire logic [7:0] data;
   wire logic [6:0] i2c_id, pmb_id;
   pwrini_top u_pwrini_top (.CLK_I(clk), .SRST_I(srst), .BIAS_GOOD_I(bias), .CORE_RAIL_1V8_GOOD_I(core),
      .OSC_STABLE_I(osc), .ENABLE_FORCED_MODE_PIN_I(pin), .VIN_LEVEL_I(vin), .ADC_START_O(adc_start),
      .ADC_DONE_I(adc_done), .ADC_DATA_I(adc), .CMD_WE_I(we), .CMD_IDX_I(idx), .CMD_DATA_I(data),
      .CMD_READY_O(ready), .I2C_SLAVE_ID_O(i2c_id), .PMBUS_SLAVE_ID_O(pmb_id), .I2C_ON_O(i2c_on),
      .PMBUS_ON_O(pmb_on), .ANALOG_MODE_O(analog), .INIT_DONE_O(init), .CONVERT_EN_O(conv));
   pwrini_host u_host (.clk_i(clk), .ready_i(ready), .we_o(we), .idx_o(idx), .data_o(data));
   initial forever #50 clk = ~clk;
   task summarize;
      if (fail_count == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task rpt(input int n);
      repeat (n) @(negedge clk);
   endtask
   // bounded wait for strap request or init done
   task wt(input bit s);
      int j;
      for (j = 0; j < 200; j++) begin
         @(negedge clk);
         if ((s ? init : adc_start) === 1'b1) return;
      end
      fail_count++;
      summarize();
   endtask
   task strap(input logic [9:0] a);
      wt(0);
      adc = a;
      adc_done = 1;
      rpt(4);
      adc_done = 0;
      adc = ~a;
      wt(1);
   endtask
   task w(input logic [3:0] i, input logic [7:0] v);
      u_host.wr(i, v, 1'b0, $random(seed) & 3, ok);
      if (!ok) begin
         fail_count++;
         summarize();
      end
   endtask
   // note an expected status; the monitor takes it
   task ex(input logic [19:0] m, input logic [19:0] x);
      q.push_back({m, x});
      ->smp;
   endtask
   task cmp(input logic [39:0] n);
      logic [19:0] o;
      o = {i2c_on, pmb_on, analog, init, conv, ready, i2c_id, pmb_id} & n[39:20];
      n_tests++;
      if (o !== (n[19:0] & n[39:20])) begin
         fail_count++;
         $display("CHECK FAILED status exp %h seen %h", n[19:0] & n[39:20], o);
      end
   endtask
   // monitor: oldest note against the settled outputs
   initial forever begin
      @(smp);
      #1;
      while (q.size() > 0) cmp(q.pop_front());
   end
   // main sequence
   initial begin
      for (k = 0; k < 16; k++) begin
         srst = 1;
         rpt(3);
         srst = 0;
         of = 7'(k);
         rb = 6'($random(seed)) & 6'h2f; // keeps offset 15 below the float band
         strap({of[3:0], rb});
         rpt(6);
         ex(M_ALL, {6'b110101, 7'h10 + of, 7'h40 + of});
      end
      d = 7'($random(seed)) | 7'h1;
      e = 7'($random(seed)) | 7'h1;
      w(4'h0, {1'b0, d});
      w(4'h1, {1'b0, e});
      rpt(3);
      ex(M_ALL, {6'b110101, d + of, e + of});
      w(4'h0, 8'h00);
      rpt(3);
      ex(20'hc0000, 20'h40000);
      pin = 1;
      rpt(6);
      ex(M_CONV, M_CONV);
      vin = 8'h10;
      rpt(6);
      ex(M_CONV, 20'h0);
      w(4'h2, 8'h40);
      w(4'h3, 8'h38);
      for (k = 0; k < 5; k++) begin
         vin = vin_tab[k][8:1];
         rpt(6);
         ex(M_CONV, {4'h0, vin_tab[k][0], 15'h0});
      end
      for (k = 0; k < 6; k++) begin
         w(4'h4, {5'h0, src_tab[k][4:2]});
         pin = src_tab[k][1];
         rpt(6);
         ex(M_CONV, {4'h0, src_tab[k][0], 15'h0});
      end
      bias = 0;
      rpt(6);
      ex(M_FLG, 20'h0);
      bias = 1;
      strap({of[3:0], rb});
      rpt(6);
      ex(M_ALL, {6'b110111, 7'h10 + of, 7'h40 + of});
      srst = 1;
      rpt(3);
      srst = 0;
      strap(10'h3f0 | {6'h0, rb[3:0]});
      rpt(6);
      ex(M_FLG, 20'h38000);
      u_host.wr(4'h0, 8'h22, 1'b1, 0, ok);
      pin = 0;
      rpt(6);
      ex(M_ALL, {6'b001100, 7'h10, 7'h40});
      rpt(2);
      summarize();
   end
endmodule
`default_nettype wire
